// >>> verilog/pld_ctrl.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module pld_ctrl #(
  parameter int OFF_CYC = pld_pkg::CYC_OFF, // low time to shutdown
  parameter int PDN_CYC = pld_pkg::CYC_PDN, // power-down delay
  parameter int HI_MAX_CYC = pld_pkg::CYC_HI_MAX, // longest pulse phase
  parameter int TMO_CYC = pld_pkg::CYC_DATA_TMO, // data wait timeout
  parameter int FILT_CYC = pld_pkg::CYC_FILT // pump step-up delay
) (
  input wire logic mclk, // 50 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire pld_pkg::pld_sense_t sense, // line and comparator levels
  input wire logic [3:0] avs_address, // avalon byte address
  input wire logic avs_read, // avalon read
  input wire logic avs_write, // avalon write
  input wire logic [31:0] avs_writedata, // avalon write data
  input wire logic [3:0] avs_byteenable, // avalon byte lanes
  output logic [31:0] avs_readdata, // avalon read data
  output logic avs_waitrequest, // avalon wait
  output pld_pkg::pld_drive_t drive_q, // led sink channel controls
  output pld_pkg::pld_pump_mode_t pump_mode // pump ratio mode
);
  localparam int CW = pld_pkg::CNT_W;
  localparam logic [CW-1:0] OFF_LAST = CW'(OFF_CYC - 1);
  localparam logic [CW-1:0] PDN_END = CW'(OFF_CYC + PDN_CYC - 1);
  localparam logic [CW-1:0] HI_LAST = CW'(HI_MAX_CYC);
  localparam logic [CW-1:0] TMO_LAST = CW'(TMO_CYC);
  localparam logic [CW-1:0] SETUP_LAST = CW'(pld_pkg::CYC_SETUP);
  localparam logic [pld_pkg::GL_W-1:0] GL_LAST =
    pld_pkg::GL_W'(pld_pkg::CYC_GLITCH - 1);

  pld_pkg::pld_sense_t sense_s;
  pld_pkg::pld_state_t state_q, state_d;
  pld_pkg::pld_drive_t drive_d;
  logic [pld_pkg::NUM_REGS-1:0][pld_pkg::REG_W-1:0] regs_q, regs_d;
  logic [2:0] sel_q, sel_d;
  logic [4:0] cnt_q, cnt_d;
  logic [CW-1:0] hi_q, hi_d, lo_q, lo_d;
  logic [pld_pkg::GL_W-1:0] gl_q, gl_d;
  logic line_q, line_d;
  logic fall_e, rise_e, enabled, force_off, lock;
  logic pump_rst_q, pump_rst_d;
  logic [31:0] ctrl_q, ctrl_d, rdata_d, rd_mux;
  logic wait_d, wr_take;

  // pin-side levels through two flops before any use
  pld_sync2 u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .raw(sense),
    .sync(sense_s)
  );

  // charge pump ratio sequencer
  pld_pump_seq #(
    .FILT_CYC(FILT_CYC)
  ) u_pump (
    .mclk(mclk),
    .arst_n(arst_n),
    .active(enabled && !sense_s.uvlo),
    .restart(pump_rst_q),
    .reg_fail(sense_s.reg_fail),
    .in_ok(sense_s.in_ok),
    .lock(lock),
    .mode_q(pump_mode)
  );

  assign enabled = (state_q != pld_pkg::ST_OFF) &&
                   (state_q != pld_pkg::ST_PDN);
  assign force_off = ctrl_q[pld_pkg::CTRL_FORCE_OFF_BIT];
  assign lock = regs_q[pld_pkg::IDX_LOCK][pld_pkg::BIT_LOCK];

  // glitch filter: a level must hold for 200 ns to be taken
  always_comb begin
    line_d = line_q;
    gl_d = '0;
    if (sense_s.line != line_q) begin
      if (gl_q == GL_LAST) begin
        line_d = sense_s.line;
      end else begin
        gl_d = gl_q + 1'b1;
      end
    end
  end

  assign fall_e = line_q && !line_d;
  assign rise_e = !line_q && line_d;

  // high time since last rising edge and low time since last fall
  always_comb begin
    hi_d = '0;
    lo_d = '0;
    if (line_d && !rise_e) begin
      hi_d = pld_pkg::sat_inc(hi_q);
    end
    if (!line_d && !fall_e) begin
      lo_d = pld_pkg::sat_inc(lo_q);
    end
  end

  // enable, shutdown and programming sequence
  always_comb begin
    state_d = state_q;
    regs_d = regs_q;
    sel_d = sel_q;
    cnt_d = cnt_q;
    pump_rst_d = 1'b0;
    case (state_q)
      pld_pkg::ST_OFF: begin
        if (rise_e && !force_off) begin
          state_d = pld_pkg::ST_INIT;
          regs_d = '0;
          cnt_d = '0;
        end
      end
      pld_pkg::ST_PDN: begin
        if (rise_e && !force_off) begin
          state_d = pld_pkg::ST_INIT;
          cnt_d = '0;
        end else if (lo_q >= PDN_END || line_q) begin
          state_d = pld_pkg::ST_OFF;
        end
      end
      pld_pkg::ST_INIT: begin
        // high time saturates, so the setup end is a threshold
        if (line_q && hi_q >= SETUP_LAST) begin
          state_d = pld_pkg::ST_ADDR;
          cnt_d = '0;
        end
      end
      pld_pkg::ST_ADDR: begin
        if (fall_e && cnt_q != 5'h1f) begin
          cnt_d = cnt_q + 1'b1;
        end else if (line_q && hi_q == HI_LAST && cnt_q != '0) begin
          cnt_d = '0;
          if (cnt_q <= 5'(pld_pkg::NUM_REGS)) begin
            sel_d = 3'(cnt_q - 5'h1);
            regs_d[3'(cnt_q - 5'h1)] = pld_pkg::REG_RESET;
            pump_rst_d = (cnt_q == 5'(pld_pkg::NUM_REGS));
            state_d = pld_pkg::ST_GAP;
          end
        end
      end
      pld_pkg::ST_GAP: begin
        if (fall_e) begin
          cnt_d = 5'h1;
          state_d = pld_pkg::ST_DATA;
        end else if (line_q && hi_q == TMO_LAST) begin
          state_d = pld_pkg::ST_ADDR;
        end
      end
      pld_pkg::ST_DATA: begin
        if (fall_e && cnt_q != 5'h1f) begin
          cnt_d = cnt_q + 1'b1;
        end else if (line_q && hi_q == HI_LAST) begin
          regs_d[sel_q] = pld_pkg::pulse_value(cnt_q,
            sel_q == 3'(pld_pkg::IDX_LOCK));
          cnt_d = '0;
          state_d = pld_pkg::ST_ADDR;
        end
      end
      default: state_d = pld_pkg::ST_OFF;
    endcase
    // long low or software force: shut down and lose contents
    if (enabled && (force_off || (!line_q && lo_q == OFF_LAST))) begin
      state_d = pld_pkg::ST_PDN;
      regs_d = '0;
      pump_rst_d = 1'b0;
    end else if (sense_s.uvlo) begin
      regs_d = '0;
      if (enabled) begin
        state_d = pld_pkg::ST_INIT;
      end
    end
  end

  // sink channel controls from the program registers
  always_comb begin
    drive_d.hiz = !enabled;
    drive_d.range_hi = regs_q[pld_pkg::IDX_BANK_EN][pld_pkg::BIT_RANGE];
    drive_d.bank_en = (sense_s.uvlo || !enabled) ? 3'h0 :
      regs_q[pld_pkg::IDX_BANK_EN][pld_pkg::BIT_EN_A:pld_pkg::BIT_EN_C];
    drive_d.global_code = regs_q[pld_pkg::IDX_GLOBAL];
    drive_d.code_a = regs_q[pld_pkg::IDX_CODE_A];
    drive_d.code_b = regs_q[pld_pkg::IDX_CODE_B];
    drive_d.code_c = regs_q[pld_pkg::IDX_CODE_C];
  end

  // avalon slave: one wait cycle, then answer
  always_comb begin
    rd_mux = 32'h0;
    if (avs_address == pld_pkg::OFS_CTRL) begin
      rd_mux = ctrl_q;
    end else if (avs_address == pld_pkg::OFS_REGS) begin
      rd_mux = {12'h0, regs_q[pld_pkg::IDX_CODE_C],
                regs_q[pld_pkg::IDX_CODE_B], regs_q[pld_pkg::IDX_CODE_A],
                regs_q[pld_pkg::IDX_GLOBAL], regs_q[pld_pkg::IDX_BANK_EN]};
      rd_mux[pld_pkg::REGS_LOCK_BIT] = lock;
    end else if (avs_address == pld_pkg::OFS_STAT) begin
      rd_mux[pld_pkg::STAT_STATE_LSB +: 3] = state_q;
      rd_mux[pld_pkg::STAT_MODE_LSB +: 2] = pump_mode;
      rd_mux[pld_pkg::STAT_ENABLED_BIT] = enabled;
      rd_mux[pld_pkg::STAT_UVLO_BIT] = sense_s.uvlo;
    end
    wait_d = !((avs_read || avs_write) && avs_waitrequest);
    wr_take = avs_write && !avs_waitrequest;
    rdata_d = (avs_read && avs_waitrequest) ? rd_mux : avs_readdata;
    ctrl_d = ctrl_q;
    if (wr_take && avs_address == pld_pkg::OFS_CTRL && avs_byteenable[0]) begin
      ctrl_d[pld_pkg::CTRL_FORCE_OFF_BIT] =
        avs_writedata[pld_pkg::CTRL_FORCE_OFF_BIT];
    end
  end

  // all state registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= pld_pkg::ST_OFF;
      regs_q <= '0;
      sel_q <= '0;
      cnt_q <= '0;
      hi_q <= '0;
      lo_q <= '0;
      gl_q <= '0;
      line_q <= 1'b0;
      pump_rst_q <= 1'b0;
      drive_q <= '{hiz: 1'b1, default: '0};
      ctrl_q <= pld_pkg::CTRL_RESET;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
    end else begin
      state_q <= state_d;
      regs_q <= regs_d;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      gl_q <= gl_d;
      line_q <= line_d;
      pump_rst_q <= pump_rst_d;
      drive_q <= drive_d;
      ctrl_q <= ctrl_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= wait_d;
    end
  end

  a_enable_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_OFF && rise_e && !force_off) |=>
    (regs_q == '0) ##1 (drive_q.bank_en == 3'h0))
    else $error("enable did not start with zero currents");

  a_low_shutdown: assert property (@(posedge mclk) disable iff (!arst_n)
    (enabled && !line_q && lo_q == OFF_LAST) |=>
    (state_q == pld_pkg::ST_PDN && regs_q == '0))
    else $error("long low did not shut down");

  a_pdn_lost: assert property (@(posedge mclk) disable iff (!arst_n)
    state_q == pld_pkg::ST_PDN |-> regs_q == '0)
    else $error("registers kept during power-down");

  a_off_hiz: assert property (@(posedge mclk) disable iff (!arst_n)
    (!enabled) |=> (drive_q.hiz && drive_q.bank_en == 3'h0))
    else $error("sinks not high-impedance in shutdown");

  a_uvlo_default: assert property (@(posedge mclk) disable iff (!arst_n)
    sense_s.uvlo |=> (regs_q == '0) ##1 (drive_q.bank_en == 3'h0))
    else $error("undervoltage did not reset registers");

  a_select_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_GAP && $past(state_q) == pld_pkg::ST_ADDR) |->
    (regs_q[sel_q] == '0 && 5'(sel_q) == $past(cnt_q) - 5'h1))
    else $error("selected register not cleared");

  a_data_load: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_DATA && state_d == pld_pkg::ST_ADDR &&
     !sense_s.uvlo) |=> regs_q[$past(sel_q)] ==
     pld_pkg::pulse_value($past(cnt_q),
                          $past(sel_q) == 3'(pld_pkg::IDX_LOCK)))
    else $error("data pulses loaded a wrong value");

  a_data_timeout: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_GAP && line_q && line_d && hi_q == TMO_LAST &&
     !force_off && !sense_s.uvlo) |=> state_q == pld_pkg::ST_ADDR)
    else $error("gap timeout did not return to address");

  a_return_lock_register_restart: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_GAP && $past(state_q) == pld_pkg::ST_ADDR &&
     sel_q == 3'(pld_pkg::IDX_LOCK)) |-> pump_rst_q ##1
    pump_mode == pld_pkg::PM_1X)
    else $error("register six did not restart the pump");

  a_bus_answer: assert property (@(posedge mclk) disable iff (!arst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");

  a_glitch_filter: assert property (@(posedge mclk) disable iff (!arst_n)
    $changed(line_q) |-> $past(gl_q) == GL_LAST)
    else $error("line level taken before the glitch span");

  a_init_setup: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_INIT && state_d == pld_pkg::ST_ADDR) |->
    (line_q && hi_q >= SETUP_LAST))
    else $error("address phase opened before the setup time");

  a_addr_count: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_ADDR && fall_e && cnt_q != 5'h1f &&
     !force_off) |=> cnt_q == $past(cnt_q) + 5'h1)
    else $error("address falling edge not counted");

  a_gap_data: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == pld_pkg::ST_GAP && fall_e && !force_off &&
     !sense_s.uvlo) |=> (state_q == pld_pkg::ST_DATA && cnt_q == 5'h1))
    else $error("first data edge did not open the data phase");

  a_force_off: assert property (@(posedge mclk) disable iff (!arst_n)
    (enabled && force_off) |=> (state_q == pld_pkg::ST_PDN && regs_q == '0))
    else $error("forced shutdown did not clear the device");
endmodule : pld_ctrl
`default_nettype wire

// >>> verilog/pld_pkg.sv
`default_nettype none
package pld_pkg;
  // clock and documented times, each in its own unit
  localparam real CLK_PERIOD_NS = 20.0;
  localparam real T_GLITCH_NS = 200.0;
  localparam real PULSE_HIGH_MAX_US = 100.0;
  localparam real T_SETUP_US = 10.0;
  localparam real T_OFF_MS = 1.5;
  localparam real T_PDN_MS = 1.0;
  localparam real T_DATA_TMO_US = 1000.0;
  localparam real T_FILT_US = 400.0;

  // cycle counts: least times and the longest pulse high round up, the other times round down
  localparam int CYC_GLITCH = int'($ceil(T_GLITCH_NS / CLK_PERIOD_NS));
  localparam int CYC_SETUP = int'($ceil(T_SETUP_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int CYC_HI_MAX =
    int'($ceil(PULSE_HIGH_MAX_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int CYC_OFF = int'($ceil(T_OFF_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int CYC_PDN = int'($floor(T_PDN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int CYC_DATA_TMO =
    int'($floor(T_DATA_TMO_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int CYC_FILT = int'($floor(T_FILT_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int CNT_W = 20;
  localparam int GL_W = 4;

  // program registers
  localparam int NUM_REGS = 6;
  localparam int REG_W = 4;
  localparam int IDX_BANK_EN = 0;
  localparam int IDX_GLOBAL = 1;
  localparam int IDX_CODE_A = 2;
  localparam int IDX_CODE_B = 3;
  localparam int IDX_CODE_C = 4;
  localparam int IDX_LOCK = 5;
  localparam int BIT_RANGE = 3;
  localparam int BIT_EN_A = 2;
  localparam int BIT_EN_C = 0;
  localparam int BIT_LOCK = 0;
  localparam logic [3:0] REG_RESET = 4'h0;

  // avalon register map, byte addresses
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_REGS = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam int CTRL_FORCE_OFF_BIT = 0;
  localparam int REGS_LOCK_BIT = 20;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_ENABLED_BIT = 8;
  localparam int STAT_UVLO_BIT = 9;

  typedef enum logic [1:0] {PM_1X, PM_133X, PM_15X, PM_2X} pld_pump_mode_t;
  typedef enum logic [2:0] {
    ST_OFF, ST_PDN, ST_INIT, ST_ADDR, ST_GAP, ST_DATA
  } pld_state_t;

  typedef struct packed {
    logic line;
    logic uvlo;
    logic reg_fail;
    logic in_ok;
  } pld_sense_t;

  typedef struct packed {
    logic hiz;
    logic range_hi;
    logic [2:0] bank_en;
    logic [3:0] global_code;
    logic [3:0] code_a;
    logic [3:0] code_b;
    logic [3:0] code_c;
  } pld_drive_t;

  // register value for n data pulses; the one-bit register is set by one
  function automatic logic [3:0] pulse_value(input logic [4:0] n,
                                             input logic one_bit);
    logic [4:0] neg;
    neg = 5'h0 - n;
    if (one_bit) begin
      pulse_value = {3'h0, (n == 5'h01)};
    end else begin
      pulse_value = neg[3:0];
    end
  endfunction : pulse_value

  // saturating increment of an interval counter
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    if (&c) begin
      sat_inc = c;
    end else begin
      sat_inc = c + 1'b1;
    end
  endfunction : sat_inc
endpackage : pld_pkg
`default_nettype wire

// >>> verilog/pld_sync2.sv
`default_nettype none
module pld_sync2 (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire pld_pkg::pld_sense_t raw, // pin-side levels
  output var pld_pkg::pld_sense_t sync // levels after two flops
);
  pld_pkg::pld_sense_t meta_q;
  pld_pkg::pld_sense_t meta_d;
  pld_pkg::pld_sense_t sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = raw;
    sync_d = meta_q;
  end

  // two-flop synchroniser
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync <= '0;
    end else begin
      meta_q <= meta_d;
      sync <= sync_d;
    end
  end
endmodule : pld_sync2
`default_nettype wire

// >>> verilog/pld_pump_seq.sv
`default_nettype none
module pld_pump_seq #(
  parameter int FILT_CYC = pld_pkg::CYC_FILT // step-up filter delay
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic active, // device enabled and supply good
  input wire logic restart, // one-cycle pulse: back to 1x
  input wire logic reg_fail, // regulation lost
  input wire logic in_ok, // supply can drive all in 1x
  input wire logic lock, // blocks automatic return to 1x
  output var pld_pkg::pld_pump_mode_t mode_q // current ratio mode
);
  localparam int CW = pld_pkg::CNT_W;
  localparam logic [CW-1:0] FILT_LAST = CW'(FILT_CYC - 1);

  pld_pkg::pld_pump_mode_t mode_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // mode selection with filtered step-up and direct return
  always_comb begin
    mode_d = mode_q;
    cnt_d = '0;
    if (!active || restart) begin
      mode_d = pld_pkg::PM_1X;
    end else if (in_ok && !lock && mode_q != pld_pkg::PM_1X) begin
      mode_d = pld_pkg::PM_1X;
    end else if (reg_fail && mode_q != pld_pkg::PM_2X) begin
      if (cnt_q == FILT_LAST) begin
        case (mode_q)
          pld_pkg::PM_1X: mode_d = pld_pkg::PM_133X;
          pld_pkg::PM_133X: mode_d = pld_pkg::PM_15X;
          default: mode_d = pld_pkg::PM_2X;
        endcase
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // mode and filter counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= pld_pkg::PM_1X;
      cnt_q <= '0;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
    end
  end

  a_pump_restart: assert property (@(posedge mclk) disable iff (!arst_n)
    restart |=> mode_q == pld_pkg::PM_1X)
    else $error("pump not back in 1x after restart");

  a_pump_hold_1x: assert property (@(posedge mclk) disable iff (!arst_n)
    (mode_q == pld_pkg::PM_1X && !reg_fail) |=> mode_q == pld_pkg::PM_1X)
    else $error("pump left 1x while regulating");

  a_pump_first_step: assert property (@(posedge mclk) disable iff (!arst_n)
    (active && !restart && reg_fail && mode_q == pld_pkg::PM_1X &&
     cnt_q == FILT_LAST) |=> mode_q == pld_pkg::PM_133X)
    else $error("pump did not step to 1.33x after filter");

  a_pump_one_up: assert property (@(posedge mclk) disable iff (!arst_n)
    (mode_q != pld_pkg::PM_1X && $changed(mode_q)) |->
    (2'(mode_q) == 2'(2'($past(mode_q)) + 2'h1)))
    else $error("pump moved other than one step up");

  a_pump_locked: assert property (@(posedge mclk) disable iff (!arst_n)
    (lock && active && !restart && mode_q != pld_pkg::PM_1X) |=>
    mode_q != pld_pkg::PM_1X)
    else $error("pump returned to 1x while locked");
endmodule : pld_pump_seq
`default_nettype wire

// >>> bench/pld_host.sv
`default_nettype none
// host side of the single-wire line; idle low like the pull-down
module pld_host (
  input wire logic mclk, // system clock
  output var logic line // enable and program line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line = 1'b0;

  // hold the line at one level for c cycles
  task automatic hold(input logic v, input int c);
    line <= v;
    repeat (c) @(posedge mclk);
  endtask : hold

  // n falling edges, each phase 20 cycles
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      hold(1'b0, 20);
      hold(1'b1, 20);
    end
  endtask : pulses

  // address first, then gap, data and a settle time
  task automatic send_reg(input int a, input int n);
    pulses(a);
    hold(1'b1, 150);
    pulses(n);
    hold(1'b1, 200);
  endtask : send_reg
endmodule : pld_host
`default_nettype wire

// >>> bench/tb_pulse_count_led_driver_control.sv
`default_nettype none
module tb_pulse_count_led_driver_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic uvlo = 1'b0;
  logic reg_fail = 1'b0;
  logic in_ok = 1'b0;
  logic line;
  pld_pkg::pld_sense_t sense;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest;
  pld_pkg::pld_drive_t drive_q;
  pld_pkg::pld_pump_mode_t pump_mode;
  logic [20:0] exp_r = 21'h0;
  int miscompares = 0;
  int check_count = 0;

  // clock and sense bundle
  always #10 mclk = ~mclk;
  assign sense = '{line: line, uvlo: uvlo, reg_fail: reg_fail, in_ok: in_ok};

  pld_host host (.mclk(mclk), .line(line));

  pld_ctrl #(.OFF_CYC(200), .PDN_CYC(50), .HI_MAX_CYC(60), .TMO_CYC(300),
    .FILT_CYC(20)) uut (.mclk(mclk), .arst_n(arst_n), .sense(sense),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .drive_q(drive_q), .pump_mode(pump_mode));

  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    rd = avs_readdata;
    chk(32'(n < 50), 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk

  // program one register and compare the register image
  task automatic prog(input int a, input int n);
    host.send_reg(a, n);
    if (a == 6) begin
      exp_r[20] = (n == 1);
    end else begin
      exp_r[a*4-4 +: 4] = 4'(16 - n);
    end
    rdchk(pld_pkg::OFS_REGS, {11'h0, exp_r});
  endtask : prog

  // wait for a pump mode, checking that it took more than 15 cycles
  task automatic wmode(input pld_pkg::pld_pump_mode_t m);
    int n;
    n = 0;
    while (pump_mode !== m && n < 60) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n > 15), 32'h1);
    chk(32'(pump_mode), 32'(m));
  endtask : wmode

  // watchdog
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk(32'(drive_q.hiz), 32'h1);
    rdchk(pld_pkg::OFS_STAT, 32'h0);
    bus(1'b1, pld_pkg::OFS_CTRL, 32'h1);
    rdchk(pld_pkg::OFS_CTRL, 32'h1);
    bus(1'b1, pld_pkg::OFS_CTRL, 32'h0);
    rdchk(pld_pkg::OFS_CTRL, 32'h0);
    avs_byteenable <= 4'he;
    bus(1'b1, pld_pkg::OFS_CTRL, 32'h1);
    avs_byteenable <= 4'hf;
    rdchk(pld_pkg::OFS_CTRL, 32'h0);
    rdchk(4'hc, 32'h0);
    bus(1'b1, pld_pkg::OFS_REGS, 32'hffffffff);
    host.hold(1'b1, 600);
    chk(32'(drive_q), 32'h0);
    rdchk(pld_pkg::OFS_STAT, 32'h103);
    host.hold(1'b0, 3);
    host.hold(1'b1, 20);
    prog(2, 1);
    prog(1, 9);
    chk(32'({drive_q.range_hi, drive_q.bank_en}), 32'h7);
    prog(3, 5);
    prog(4, 16);
    prog(5, 15);
    chk(32'({drive_q.global_code, drive_q.code_a, drive_q.code_b,
      drive_q.code_c}), 32'hfb01);
    prog(3, 0);
    rdchk(pld_pkg::OFS_STAT, 32'h103);
    prog(6, 1);
    reg_fail <= 1'b1;
    wmode(pld_pkg::PM_133X);
    wmode(pld_pkg::PM_15X);
    wmode(pld_pkg::PM_2X);
    reg_fail <= 1'b0;
    in_ok <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(32'(pump_mode), 32'(pld_pkg::PM_2X));
    in_ok <= 1'b0;
    prog(6, 1);
    chk(32'(pump_mode), 32'(pld_pkg::PM_1X));
    prog(6, 2);
    reg_fail <= 1'b1;
    wmode(pld_pkg::PM_133X);
    reg_fail <= 1'b0;
    in_ok <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(pump_mode), 32'(pld_pkg::PM_1X));
    uvlo <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(32'(drive_q.bank_en), 32'h0);
    exp_r = 21'h0;
    rdchk(pld_pkg::OFS_REGS, 32'h0);
    uvlo <= 1'b0;
    repeat (600) @(posedge mclk);
    prog(2, 1);
    host.hold(1'b0, 150);
    chk(32'(drive_q.hiz), 32'h0);
    host.hold(1'b0, 100);
    chk(32'(drive_q.hiz), 32'h1);
    rdchk(pld_pkg::OFS_REGS, 32'h0);
    host.hold(1'b0, 60);
    rdchk(pld_pkg::OFS_STAT, 32'h0);
    host.hold(1'b1, 30);
    rdchk(pld_pkg::OFS_STAT, 32'h102);
    bus(1'b1, pld_pkg::OFS_CTRL, 32'h1);
    host.hold(1'b0, 20);
    host.hold(1'b1, 30);
    rdchk(pld_pkg::OFS_STAT, 32'h0);
    bus(1'b1, pld_pkg::OFS_CTRL, 32'h0);
    test_done();
  end
endmodule : tb_pulse_count_led_driver_control
`default_nettype wire
